// file: shared/atbw_pkg.sv
// Constants and types for the tracking, burst and window control block
package atbw_pkg;
  // Register addresses, all on page 0x00
  localparam logic [7:0] SFR_PAGE_TRACK  = 8'h00;
  localparam logic [7:0] ADDR_TRACK      = 8'hba;
  localparam logic [7:0] ADDR_CONTROL    = 8'he8;
  localparam logic [7:0] ADDR_UPPER_LOW  = 8'hc3;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hc4;
  localparam logic [7:0] ADDR_LOWER_LOW  = 8'hc5;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hc6;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbe;
  // Reset values
  localparam logic [7:0]  TRACK_RESET   = 8'hff;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] UPPER_RESET   = 16'hffff;
  localparam logic [15:0] LOWER_RESET   = 16'h0000;
  // Field positions in the tracking register
  localparam int PWR_MSB = 7;
  localparam int PWR_LSB = 4;
  localparam int TM_MSB  = 3;
  localparam int TM_LSB  = 2;
  localparam int TK_MSB  = 1;
  localparam int TK_LSB  = 0;
  // Bit positions in the control register
  localparam int CTL_ENABLE = 7;
  localparam int CTL_BURST  = 6;
  localparam int CTL_WFLAG  = 3;
  // Timing
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int BURST_UNIT_NS    = 200;
  localparam int BURST_UNIT_CYC   = (BURST_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] POST_SYSTEM_CLOCK_CYC = 2'h2;
  localparam logic [4:0] POST_SAR_00 = 5'h02;
  localparam logic [4:0] POST_SAR_01 = 5'h04;
  localparam logic [4:0] POST_SAR_10 = 5'h08;
  localparam logic [4:0] POST_SAR_11 = 5'h10;
  // Tracking mode codes
  typedef enum logic [1:0]
  {
    ATBW_TM_RSVD = 2'h0,
    ATBW_TM_POST = 2'h1,
    ATBW_TM_PRE  = 2'h2,
    ATBW_TM_DUAL = 2'h3
  } atbw_tm_t;
  // Sequencer states, Gray along the path
  typedef enum logic [1:0]
  {
    ATBW_IDLE  = 2'b00,
    ATBW_WAKE  = 2'b01,
    ATBW_TRACK = 2'b11,
    ATBW_CONV  = 2'b10
  } atbw_state_t;
endpackage

// file: shared/atbw_win_if.sv
// Carrier between the sequencer and the window comparator
`timescale 1ns/1ns
`default_nettype none
interface atbw_win_if;
  logic [15:0] result;
  logic [15:0] upper;
  logic [15:0] lower;
  logic        hit;
  modport ctrl (output result, output upper, output lower, input hit);
  modport det (input result, input upper, input lower, output hit);
endinterface
`default_nettype wire

// file: src/atbw_window.sv
// Window comparator on the converted result
`timescale 1ns/1ns
`default_nettype none
module atbw_window
(
  atbw_win_if.det win
);
  wire inside_mode;
  wire above_upper;
  wire below_lower;

  assign above_upper = win.result > win.upper;
  assign below_lower = win.result < win.lower;
  assign inside_mode = win.lower > win.upper;
  assign win.hit = inside_mode ? (above_upper && below_lower) : (above_upper || below_lower);
endmodule
`default_nettype wire

// file: src/atbw_ctrl.sv
// Burst power-up, tracking sequence and window flag control
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Burst off: power follows converter enable
// - Burst on, enabled: converter stays powered
// - Burst on, disabled: sleep, wake per start
// - Wake wait is (field plus one) times 200ns
// - Mode field picks post, pre or dual
// - Post-track length 2/4/8/16 clocks plus two
// - Tracking register at 0xBA, resets all ones
// - Compare result against programmed limits
// - Flag is both interrupt and status
// - Upper and lower limits, high/low bytes
// - Limit order selects inside or outside
module atbw_ctrl
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_page,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  // Converter side
  input  wire logic        conv_start,
  input  wire logic        sar_tick,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  output var  logic        conv_power,
  output var  logic        conv_track,
  output var  logic        conv_go,
  output var  logic        seq_busy,
  // Window flag
  output var  logic        window_irq
);
  import atbw_pkg::*;

  atbw_win_if win ();

  atbw_state_t state_q;
  atbw_state_t state_d;
  logic [7:0]  track_q;
  logic [7:0]  ctl_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] result_q;
  logic        flag_q;
  logic        eval_q;
  logic [9:0]  cnt_q;
  logic [9:0]  cnt_d;
  logic        system_clock_phase_q;
  logic        system_clock_phase_d;
  logic [7:0]  rdata_d;
  logic        power_q;
  logic        track_o_q;
  logic        go_q;
  logic        busy_q;

  wire       page_ok;
  wire       wr_track;
  wire       wr_ctl;
  wire       wr_ul;
  wire       wr_uh;
  wire       wr_ll;
  wire       wr_lh;
  wire       enable;
  wire       burst;
  wire [3:0] pwr_field;
  wire [1:0] tm_field;
  wire [1:0] tk_field;
  wire       post_needed;
  wire       pre_track;
  wire [4:0] post_sar;
  wire [9:0] wake_cycles;
  wire       start_ok;
  wire       sleeping;
  wire       flag_clear;

  // Register decode
  assign page_ok  = sfr_page == SFR_PAGE_TRACK;
  assign wr_track = sfr_wr && page_ok && (sfr_addr == ADDR_TRACK);
  assign wr_ctl   = sfr_wr && page_ok && (sfr_addr == ADDR_CONTROL);
  assign wr_ul    = sfr_wr && page_ok && (sfr_addr == ADDR_UPPER_LOW);
  assign wr_uh    = sfr_wr && page_ok && (sfr_addr == ADDR_UPPER_HIGH);
  assign wr_ll    = sfr_wr && page_ok && (sfr_addr == ADDR_LOWER_LOW);
  assign wr_lh    = sfr_wr && page_ok && (sfr_addr == ADDR_LOWER_HIGH);

  // Fields
  assign enable    = ctl_q[CTL_ENABLE];
  assign burst     = ctl_q[CTL_BURST];
  assign pwr_field = track_q[PWR_MSB:PWR_LSB];
  assign tm_field  = track_q[TM_MSB:TM_LSB];
  assign tk_field  = track_q[TK_MSB:TK_LSB];

  // Reserved mode code behaves as post-tracking
  assign post_needed = (tm_field != ATBW_TM_PRE);
  assign pre_track   = (tm_field == ATBW_TM_PRE) || (tm_field == ATBW_TM_DUAL);

  // Post-track converter clocks per code
  assign post_sar = (tk_field == 2'h0) ? POST_SAR_00 :
                    (tk_field == 2'h1) ? POST_SAR_01 :
                    (tk_field == 2'h2) ? POST_SAR_10 :
                    POST_SAR_11;

  // Wake time in system clocks
  assign wake_cycles = 10'((11'(pwr_field) + 11'h001) * 11'(BURST_UNIT_CYC));

  assign sleeping   = burst && !enable;
  assign start_ok   = conv_start && (enable || burst);
  assign flag_clear = wr_ctl && !sfr_wdata[CTL_WFLAG];

  // Window comparator hookup
  assign win.result = result_q;
  assign win.upper  = upper_q;
  assign win.lower  = lower_q;

  atbw_window u_window
  (
    .win (win)
  );

  // Sequencer next state
  always_comb
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    system_clock_phase_d = system_clock_phase_q;
    case (state_q)
      ATBW_IDLE:
      begin
        cnt_d        = 10'h000;
        system_clock_phase_d = 1'b0;
        if (start_ok)
        begin
          if (sleeping)
            state_d = ATBW_WAKE;
          else if (post_needed)
            state_d = ATBW_TRACK;
          else
            state_d = ATBW_CONV;
        end
      end
      ATBW_WAKE:
      begin
        cnt_d = cnt_q + 10'h001;
        if (cnt_q + 10'h001 >= wake_cycles)
        begin
          cnt_d   = 10'h000;
          state_d = post_needed ? ATBW_TRACK : ATBW_CONV;
        end
      end
      ATBW_TRACK:
      begin
        if (!system_clock_phase_q)
        begin
          if (sar_tick)
            cnt_d = cnt_q + 10'h001;
          if (sar_tick && (cnt_q + 10'h001 >= 10'(post_sar)))
          begin
            cnt_d        = 10'h000;
            system_clock_phase_d = 1'b1;
          end
        end
        else
        begin
          cnt_d = cnt_q + 10'h001;
          if (cnt_q + 10'h001 >= 10'(POST_SYSTEM_CLOCK_CYC))
          begin
            cnt_d        = 10'h000;
            system_clock_phase_d = 1'b0;
            state_d      = ATBW_CONV;
          end
        end
      end
      ATBW_CONV:
      begin
        if (conv_done)
          state_d = ATBW_IDLE;
      end
      default:
      begin
        state_d = ATBW_IDLE;
      end
    endcase
  end

  // Read data selection
  always_comb
  begin
    rdata_d = 8'h00;
    if (!page_ok)
      rdata_d = 8'h00;
    else if (sfr_addr == ADDR_TRACK)
      rdata_d = track_q;
    else if (sfr_addr == ADDR_CONTROL)
      rdata_d = {ctl_q[7:4], flag_q, ctl_q[2:0]};
    else if (sfr_addr == ADDR_UPPER_LOW)
      rdata_d = upper_q[7:0];
    else if (sfr_addr == ADDR_UPPER_HIGH)
      rdata_d = upper_q[15:8];
    else if (sfr_addr == ADDR_LOWER_LOW)
      rdata_d = lower_q[7:0];
    else if (sfr_addr == ADDR_LOWER_HIGH)
      rdata_d = lower_q[15:8];
    else if (sfr_addr == ADDR_RESULT_LOW)
      rdata_d = result_q[7:0];
    else if (sfr_addr == ADDR_RESULT_HIGH)
      rdata_d = result_q[15:8];
  end

  // Registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      track_q <= TRACK_RESET;
      ctl_q   <= CONTROL_RESET;
      upper_q <= UPPER_RESET;
      lower_q <= LOWER_RESET;
    end
    else
    begin
      if (wr_track)
        track_q <= sfr_wdata;
      if (wr_ctl)
        ctl_q <= {sfr_wdata[7:4], 1'b0, sfr_wdata[2:0]};
      if (wr_ul)
        upper_q[7:0] <= sfr_wdata;
      if (wr_uh)
        upper_q[15:8] <= sfr_wdata;
      if (wr_ll)
        lower_q[7:0] <= sfr_wdata;
      if (wr_lh)
        lower_q[15:8] <= sfr_wdata;
    end
  end

  // Result capture and window flag
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      result_q <= 16'h0000;
      flag_q   <= 1'b0;
      eval_q   <= 1'b0;
    end
    else
    begin
      if (state_q == ATBW_CONV && conv_done)
        result_q <= conv_result;
      eval_q <= (state_q == ATBW_CONV) && conv_done;
      if (eval_q && win.hit)
        flag_q <= 1'b1;
      else if (flag_clear)
        flag_q <= 1'b0;
    end
  end

  // Sequencer and outputs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q      <= ATBW_IDLE;
      cnt_q        <= 10'h000;
      system_clock_phase_q <= 1'b0;
      power_q      <= 1'b0;
      track_o_q    <= 1'b0;
      go_q         <= 1'b0;
      busy_q       <= 1'b0;
      sfr_rdata    <= 8'h00;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      system_clock_phase_q <= system_clock_phase_d;
      power_q      <= burst ? (enable || state_d != ATBW_IDLE) : enable;
      track_o_q    <= (state_d == ATBW_TRACK) || (state_d == ATBW_IDLE && pre_track && power_q);
      go_q         <= (state_d == ATBW_CONV) && (state_q != ATBW_CONV);
      busy_q       <= state_d != ATBW_IDLE;
      sfr_rdata    <= rdata_d;
    end
  end

  assign seq_busy   = busy_q;
  assign conv_power = power_q;
  assign conv_track = track_o_q;
  assign conv_go    = go_q;
  assign window_irq = flag_q;
endmodule
`default_nettype wire

// file: verification/atbw_ctrl_assertions.sv
// Port checks for the control block
`timescale 1ns/1ns
`default_nettype none
module atbw_ctrl_assertions
  import atbw_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Converter side
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic       conv_power,
  input wire logic       conv_go,
  input wire logic       seq_busy,
  // Window flag
  input wire logic       window_irq
);
  logic en_q;
  logic bu_q;
  logic cv_q;
  wire  ctl_wr = sfr_wr && sfr_page == SFR_PAGE_TRACK && sfr_addr == ADDR_CONTROL;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Shadow of enable bits and convert phase
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      en_q <= 1'h0;
      bu_q <= 1'h0;
      cv_q <= 1'h0;
    end
    else
    begin
      en_q <= ctl_wr ? sfr_wdata[CTL_ENABLE] : en_q;
      bu_q <= ctl_wr ? sfr_wdata[CTL_BURST] : bu_q;
      cv_q <= conv_go || (cv_q && !conv_done);
    end
  end

  pwr_plain_a: assert property (!bu_q |=> conv_power == $past(en_q))
    else $error("power not following enable");
  pwr_burst_a: assert property (bu_q && en_q |=> conv_power)
    else $error("power dropped in burst");
  pwr_sleep_a: assert property (bu_q && !en_q && !seq_busy && !conv_start |=> !conv_power)
    else $error("power on while asleep");
  start_take_a: assert property (conv_start && !seq_busy && (en_q || bu_q) |=> seq_busy)
    else $error("start not taken");
  start_drop_a: assert property (conv_start && !seq_busy && !en_q && !bu_q |=> !seq_busy)
    else $error("start taken while off");
  go_pulse_a: assert property (conv_go |-> seq_busy ##1 !conv_go)
    else $error("go pulse malformed");
  done_end_a: assert property (conv_done && cv_q |=> !seq_busy)
    else $error("busy after done");
  flag_hold_a: assert property (window_irq && !(ctl_wr && !sfr_wdata[CTL_WFLAG]) |=> window_irq)
    else $error("flag lost");
  flag_cause_a: assert property ($rose(window_irq) |-> $past(conv_done, 2))
    else $error("flag without conversion");
  page_other_a: assert property (sfr_page != SFR_PAGE_TRACK |=> sfr_rdata == 8'h00)
    else $error("read on other page");
endmodule

bind atbw_ctrl atbw_ctrl_assertions chk_u (.mclk, .reset, .sfr_addr, .sfr_page, .sfr_wr, .sfr_wdata,
  .sfr_rdata, .conv_start, .conv_done, .conv_power, .conv_go, .seq_busy, .window_irq);
`default_nettype wire

// file: verification/adc_track_burst_window_ctrl_tb_top.sv
// Self-checking bench for the control block
`timescale 1ns/1ns
`default_nettype none
module adc_track_burst_window_ctrl_tb_top;
  import atbw_pkg::*;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic        sfr_wr = 1'h0, conv_start = 1'h0, sar_tick = 1'h0, conv_done = 1'h0;
  logic [15:0] conv_result = 16'h0000;
  logic        conv_power, conv_track, conv_go, seq_busy, window_irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  atbw_ctrl dut_u (.mclk, .reset, .sfr_addr, .sfr_page, .sfr_wr, .sfr_wdata, .sfr_rdata, .conv_start,
    .sar_tick, .conv_done, .conv_result, .conv_power, .conv_track, .conv_go, .seq_busy, .window_irq);

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(negedge mclk);
    sfr_wr = 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr_addr = a;
    @(negedge mclk);
    chk(sfr_rdata, e);
  endtask

  // Start, tick until go, then finish with a result
  task automatic conv(input logic [15:0] r, output int nt, output int nc);
    nt = 0;
    nc = 0;
    @(negedge mclk);
    conv_start = 1'h1;
    @(negedge mclk);
    conv_start = 1'h0;
    while (conv_go !== 1'h1 && nc < 400)
    begin
      sar_tick = 1'(nc % 6 == 5);
      nt += int'(sar_tick);
      @(negedge mclk);
      nc++;
    end
    sar_tick = 1'h0;
    conv_done = 1'h1;
    conv_result = r;
    @(negedge mclk);
    conv_done = 1'h0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic t_regs();
    rd(ADDR_TRACK, 8'hff);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_UPPER_HIGH, 8'hff);
    rd(ADDR_LOWER_LOW, 8'h00);
    rd(8'h00, 8'h00);
    wr(ADDR_TRACK, 8'h5a);
    rd(ADDR_TRACK, 8'h5a);
    sfr_page = 8'h01;
    rd(ADDR_TRACK, 8'h00);
    wr(ADDR_TRACK, 8'h00);
    sfr_page = 8'h00;
    rd(ADDR_TRACK, 8'h5a);
  endtask

  task automatic win(input logic [15:0] u, input logic [15:0] l, input logic [15:0] r, input logic e);
    int nt, nc;
    wr(ADDR_UPPER_HIGH, u[15:8]);
    wr(ADDR_UPPER_LOW, u[7:0]);
    wr(ADDR_LOWER_HIGH, l[15:8]);
    wr(ADDR_LOWER_LOW, l[7:0]);
    wr(ADDR_CONTROL, 8'h80);
    conv(r, nt, nc);
    chk(window_irq, e);
    rd(ADDR_CONTROL, {1'h1, 3'h0, e, 3'h0});
  endtask

  task automatic t_window();
    int nt, nc;
    wr(ADDR_TRACK, 8'h08);
    wr(ADDR_CONTROL, 8'h80);
    conv(16'h0000, nt, nc);
    chk(16'(nc), 16'h0000);
    chk(16'(conv_track), 16'h0001);
    win(16'h0100, 16'h0080, 16'h0200, 1'h1);
    win(16'h0100, 16'h0080, 16'h00c0, 1'h0);
    win(16'h0100, 16'h0080, 16'h0040, 1'h1);
    win(16'h0080, 16'h0100, 16'h00c0, 1'h1);
    win(16'h0080, 16'h0100, 16'h0200, 1'h0);
    win(16'h0080, 16'h0100, 16'h0080, 1'h0);
  endtask

  task automatic t_flag();
    int nt, nc;
    wr(ADDR_CONTROL, 8'h88);
    chk(window_irq, 1'h0);
    conv(16'h00c0, nt, nc);
    conv(16'h0200, nt, nc);
    chk(window_irq, 1'h1);
    rd(ADDR_RESULT_HIGH, 8'h02);
    rd(ADDR_RESULT_LOW, 8'h00);
  endtask

  task automatic t_post();
    int nt, nc;
    logic [4:0] n [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_TRACK, {4'h0, (i == 4 ? 2'h3 : 2'h1), 2'(i % 4)});
      conv(16'h0000, nt, nc);
      chk(16'(nt), 16'(n[i % 4]));
      chk(16'(nc), 16'(6 * n[i % 4] + 2));
      chk(16'(conv_track), 16'(i == 4));
    end
  endtask

  task automatic t_burst();
    int nt, nc;
    wr(ADDR_TRACK, 8'h18);
    wr(ADDR_CONTROL, 8'h40);
    @(negedge mclk);
    chk(conv_power, 1'h0);
    conv(16'h0000, nt, nc);
    chk(16'(nc >= 100 && nc <= 103), 16'h0001);
    chk(conv_power, 1'h0);
    wr(ADDR_CONTROL, 8'hc0);
    @(negedge mclk);
    chk(conv_power, 1'h1);
    wr(ADDR_CONTROL, 8'h00);
    conv(16'h0000, nt, nc);
    chk(seq_busy, 1'h0);
    chk(conv_power, 1'h0);
  endtask

  initial
  begin
    repeat (16) @(negedge mclk);
    reset = 1'h0;
    t_regs();
    t_window();
    t_flag();
    t_post();
    t_burst();
    stop_test();
  end

  initial
  begin
    #40000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
